// [logic/sstrm_sink.sv]
// Streaming sink end: ready generation, allowance tracking, capture buffer
`default_nettype none
module sstrm_sink
  import sstrm_pkg::*;
#(
  parameter int SYM_W     = SSTRM_SYM_W_DEF,
  parameter int SYMBOLS   = SSTRM_SYMBOLS_DEF,
  parameter int BEATS     = SSTRM_BEATS_DEF,
  parameter int ERR_W     = SSTRM_ERR_W_DEF,
  parameter int MAX_CH    = SSTRM_MAX_CH_DEF,
  parameter int RL        = SSTRM_RL_DEF,
  parameter int RA        = SSTRM_RA_UNSPEC,
  parameter bit FIRST_MSB = SSTRM_FIRST_MSB_DEF,
  parameter bit EMPTY_ALL = SSTRM_EMPTY_ALL_DEF,
  parameter int DEPTH     = sstrmEffAllow(RL, RA) + RL + 2
) (
  // Link side
  sstrm_if.snk                                              link,
  // User side, first symbol always in the top bits
  output logic                                              outValid,
  input  wire logic                                         outReady,
  output logic [SYM_W*SYMBOLS*sstrmBeatsLegal(BEATS)-1:0]   outData,
  output logic [sstrmChWidth(MAX_CH)-1:0]                   outChannel,
  output logic [ERR_W-1:0]                                  outError
);
  localparam int NSYM   = SYMBOLS * sstrmBeatsLegal(BEATS);
  localparam int SYM_WL = (SYM_W > SSTRM_SYM_W_MAX) ? SSTRM_SYM_W_MAX : SYM_W;
  localparam int DATA_W = SYM_W * NSYM;
  localparam int MAX_CL = (MAX_CH > SSTRM_MAX_CH_LIMIT) ? SSTRM_MAX_CH_LIMIT : MAX_CH;
  localparam int CH_W   = sstrmChWidth(MAX_CL);
  localparam int ENT_W  = DATA_W + CH_W + ERR_W;
  localparam int RLC    = (RL > SSTRM_RL_MAX) ? SSTRM_RL_MAX : RL;
  localparam int EFF_RA = sstrmEffAllow(RLC, RA);
  localparam int SIDX   = (RLC >= 1) ? RLC - 1 : 0;
  localparam int PTR_W  = (DEPTH < 2) ? 1 : $clog2(DEPTH);
  localparam int CNT_W  = $clog2(DEPTH + 1);
  localparam int SUM_W  = CNT_W + 5;

  // Brings symbols back to first-symbol-on-top order for the user side
  function automatic logic [DATA_W-1:0] gatherSymbols(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = d;
    if (!FIRST_MSB) begin
      for (int i = 0; i < NSYM; i++) begin
        r[i*SYM_W +: SYM_W] = d[(NSYM-1-i)*SYM_W +: SYM_W];
      end
    end
    return r;
  endfunction

  // Ready cycles already promised to the source but not yet arrived
  function automatic logic [3:0] readyInFlight(input logic [SSTRM_HIST_W-1:0] h);
    logic [3:0] n;
    n = 4'h0;
    for (int k = 0; k < RLC; k++) begin
      n = n + {3'h0, h[k]};
    end
    return n;
  endfunction

  // Wraps a buffer pointer at the buffer depth
  function automatic logic [PTR_W-1:0] nextPtr(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  logic [ENT_W-1:0]        store [DEPTH];
  logic [PTR_W-1:0]        wrPtr;
  logic [PTR_W-1:0]        rdPtr;
  logic [CNT_W-1:0]        count;
  logic [SSTRM_HIST_W-1:0] readyHist;
  logic [3:0]              allowLeft;

  // Ready cycle decode; link inputs are used without registering
  wire              readyCycle = (RLC == 0) ? link.ready : readyHist[SIDX];
  wire              inAllow    = !link.ready && (allowLeft != 4'h0);
  // Only the valid qualifier is looked at; no protocol checking of the source
  wire              capture    = link.valid && (readyCycle || inAllow);
  wire              unload     = (count != '0) && (!outValid || outReady);
  wire [SUM_W-1:0]  needSlots  = SUM_W'(count) + SUM_W'(readyInFlight(readyHist)) + SUM_W'(EFF_RA + 1);
  wire [ENT_W-1:0]  linkEntry  = {gatherSymbols(link.data), link.channel, link.error};
  wire [ENT_W-1:0]  headEntry  = store[rdPtr];

  // Keeps room for every promised ready cycle plus the allowance
  assign link.ready = link.rst_n && (needSlots <= SUM_W'(DEPTH));

  always_ff @(posedge link.clk_sys) begin
    if (capture && link.rst_n) begin
      store[wrPtr] <= linkEntry;
    end
  end

  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      wrPtr     <= '0;
      rdPtr     <= '0;
      count     <= '0;
      readyHist <= '0;
    end else begin
      readyHist <= {readyHist[SSTRM_HIST_W-2:0], link.ready};
      if (capture) begin
        wrPtr <= nextPtr(wrPtr);
      end
      if (unload) begin
        rdPtr <= nextPtr(rdPtr);
      end
      count <= count + CNT_W'(capture) - CNT_W'(unload);
    end
  end

  // Allowance reloads while ready is high, spends one per late capture
  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      allowLeft <= 4'h0;
    end else if (link.ready) begin
      allowLeft <= 4'(EFF_RA);
    end else if (capture && allowLeft != 4'h0) begin
      allowLeft <= allowLeft - 4'h1;
    end
  end

  // User-side output stage
  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      outValid   <= 1'h0;
      outData    <= '0;
      outChannel <= '0;
      outError   <= '0;
    end else if (!outValid || outReady) begin
      outValid <= unload;
      if (unload) begin
        outData    <= headEntry[ENT_W-1 -: DATA_W];
        outChannel <= headEntry[ERR_W +: CH_W];
        outError   <= headEntry[ERR_W-1:0];
      end
    end
  end

  // Unused configuration values folded into a wire that nothing reads
  wire unusedCfg = ^{SYM_WL[0], EMPTY_ALL};
endmodule
`default_nettype wire

// [logic/sstrm_pkg.sv]
// Shared constants and helper functions for the streaming source and sink ends
`default_nettype none
package sstrm_pkg;
  // Interface-wide defaults
  localparam int SSTRM_BEATS_DEF     = 1;
  localparam int SSTRM_SYM_W_DEF     = 8;
  localparam int SSTRM_SYM_W_MAX     = 512;
  localparam int SSTRM_SYMBOLS_DEF   = 4;
  localparam int SSTRM_ERR_W_DEF     = 1;
  localparam int SSTRM_MAX_CH_DEF    = 0;
  localparam int SSTRM_MAX_CH_LIMIT  = 255;
  localparam bit SSTRM_FIRST_MSB_DEF = 1'h1;
  localparam bit SSTRM_EMPTY_ALL_DEF = 1'h0;
  // Handshake timing
  localparam int SSTRM_RL_DEF        = 0;
  localparam int SSTRM_RL_MAX        = 8;
  localparam int SSTRM_RA_UNSPEC     = -1;
  localparam int SSTRM_HIST_W        = 8;
  localparam int SSTRM_SRC_SLOTS     = 2;

  // Channel field width for a given highest channel number
  function automatic int sstrmChWidth(input int maxCh);
    return (maxCh < 2) ? 1 : $clog2(maxCh + 1);
  endfunction

  // Allowance actually used: unspecified follows latency, never below a nonzero latency
  function automatic int sstrmEffAllow(input int rl, input int ra);
    if (ra < 0) begin
      return rl;
    end
    if (rl > 0 && ra < rl) begin
      return rl;
    end
    return ra;
  endfunction

  // Beats per clock limited to 1, 2, 4 or 8
  function automatic int sstrmBeatsLegal(input int beats);
    return (beats == 2 || beats == 4 || beats == 8) ? beats : 1;
  endfunction
endpackage
`default_nettype wire

// [logic/sstrm_if.sv]
// Point-to-point streaming link between one source and one sink
`default_nettype none
interface sstrm_if #(
  parameter int DATA_W = 32,
  parameter int CH_W   = 1,
  parameter int ERR_W  = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n
);
  logic [DATA_W-1:0] data;
  logic [CH_W-1:0]   channel;
  logic [ERR_W-1:0]  error;
  logic              valid;
  logic              ready;

  modport src (
    input  clk_sys,
    input  rst_n,
    input  ready,
    output data,
    output channel,
    output error,
    output valid
  );

  modport snk (
    input  clk_sys,
    input  rst_n,
    input  data,
    input  channel,
    input  error,
    input  valid,
    output ready
  );
endinterface
`default_nettype wire

// [logic/sstrm_source.sv]
// Streaming source end: two-slot buffer feeding registered link outputs
`default_nettype none
module sstrm_source
  import sstrm_pkg::*;
#(
  parameter int SYM_W     = SSTRM_SYM_W_DEF,
  parameter int SYMBOLS   = SSTRM_SYMBOLS_DEF,
  parameter int BEATS     = SSTRM_BEATS_DEF,
  parameter int ERR_W     = SSTRM_ERR_W_DEF,
  parameter int MAX_CH    = SSTRM_MAX_CH_DEF,
  parameter int RL        = SSTRM_RL_DEF,
  parameter bit FIRST_MSB = SSTRM_FIRST_MSB_DEF
) (
  // Link side
  sstrm_if.src                                              link,
  // User side, first symbol always in the top bits
  input  wire logic                                         inValid,
  output logic                                              inReady,
  input  wire logic [SYM_W*SYMBOLS*sstrmBeatsLegal(BEATS)-1:0] inData,
  input  wire logic [sstrmChWidth(MAX_CH)-1:0]              inChannel,
  input  wire logic [ERR_W-1:0]                             inError
);
  localparam int NSYM   = SYMBOLS * sstrmBeatsLegal(BEATS);
  localparam int DATA_W = SYM_W * NSYM;
  localparam int CH_W   = sstrmChWidth(MAX_CH);
  localparam int ENT_W  = DATA_W + CH_W + ERR_W;
  localparam int HIDX   = (RL >= 2) ? RL - 2 : 0;

  // Places symbols on the link in the configured order
  function automatic logic [DATA_W-1:0] placeSymbols(input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    r = d;
    if (!FIRST_MSB) begin
      for (int i = 0; i < NSYM; i++) begin
        r[i*SYM_W +: SYM_W] = d[(NSYM-1-i)*SYM_W +: SYM_W];
      end
    end
    return r;
  endfunction

  logic [ENT_W-1:0]        slot [SSTRM_SRC_SLOTS];
  logic                    wrPtr;
  logic                    rdPtr;
  logic [1:0]              slotCount;
  logic [SSTRM_HIST_W-1:0] readyHist;

  wire              push      = inValid && inReady;
  // Ready seen early enough that our registered valid lands in a ready cycle
  wire              readySoon = (RL == 1) ? link.ready : readyHist[HIDX];
  wire              advance   = (RL == 0) ? (!link.valid || link.ready) : 1'h1;
  wire              send      = advance && (slotCount != 2'h0) && ((RL == 0) || readySoon);
  wire [ENT_W-1:0]  headEntry = slot[rdPtr];

  assign inReady = (slotCount != 2'h2);

  always_ff @(posedge link.clk_sys) begin
    if (push) begin
      slot[wrPtr] <= {placeSymbols(inData), inChannel, inError};
    end
  end

  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      wrPtr     <= 1'h0;
      rdPtr     <= 1'h0;
      slotCount <= 2'h0;
      readyHist <= '0;
    end else begin
      readyHist <= {readyHist[SSTRM_HIST_W-2:0], link.ready};
      if (push) begin
        wrPtr <= ~wrPtr;
      end
      if (send) begin
        rdPtr <= ~rdPtr;
      end
      slotCount <= slotCount + {1'h0, push} - {1'h0, send};
    end
  end

  // All link outputs come straight from flip-flops
  always_ff @(posedge link.clk_sys or negedge link.rst_n) begin
    if (!link.rst_n) begin
      link.valid   <= 1'h0;
      link.data    <= '0;
      link.channel <= '0;
      link.error   <= '0;
    end else if (advance) begin
      link.valid <= send;
      if (send) begin
        link.data    <= headEntry[ENT_W-1 -: DATA_W];
        link.channel <= headEntry[ERR_W +: CH_W];
        link.error   <= headEntry[ERR_W-1:0];
      end
    end
  end
endmodule
`default_nettype wire

// [verification/sstrm_chk.sv]
// Link protocol checker for the streaming source and sink pair
`default_nettype none
module sstrm_chk
  import sstrm_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int CH_W   = 1,
  parameter int ERR_W  = 1,
  parameter int MAX_CH = 0
) (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // Link signals
  input wire logic [DATA_W-1:0] data,
  input wire logic [CH_W-1:0]   channel,
  input wire logic [ERR_W-1:0]  error,
  input wire logic              valid,
  input wire logic              ready
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence stallSeq;
    valid && !ready;
  endsequence

  sequence xferSeq;
    valid && ready;
  endsequence

  rst_quiet_a: assert property (disable iff (1'b0) !rst_n |-> !valid && !ready)
    else $error("link not idle in reset");
  first_idle_a: assert property ($rose(rst_n) |-> !valid)
    else $error("valid at first edge after reset");
  ready_up_a: assert property ($rose(rst_n) |-> ##[0:2] ready)
    else $error("empty sink not ready after reset");
  stall_hold_a: assert property (stallSeq |=> valid)
    else $error("valid dropped while stalled");
  stall_data_a: assert property (stallSeq |=> $stable(data))
    else $error("data changed while stalled");
  stall_tag_a: assert property (stallSeq |=> $stable(channel) && $stable(error))
    else $error("channel or error changed while stalled");
  ch_max_a: assert property (xferSeq |-> channel <= MAX_CH)
    else $error("channel above highest channel");
  ready_drop_a: assert property ($fell(ready) |-> $past(valid && ready))
    else $error("ready fell without a capture");
endmodule
`default_nettype wire

// [verification/test_stream_source_sink_handshake.sv]
// Self-checking bench: source and sink ends joined over one link
`default_nettype none
module test_stream_source_sink_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DATA_W    = 32;
  localparam int CH_W      = 2;
  localparam int ERR_W     = 2;
  localparam int MAX_CH    = 2;
  localparam bit FIRST_MSB = 1'h0;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        inValid = 1'b0;
  logic        inReady;
  logic [31:0] inData = 32'h0;
  logic [1:0]  inChannel = 2'h0;
  logic [1:0]  inError = 2'h0;
  logic        outValid;
  logic        outReady = 1'b0;
  logic [31:0] outData;
  logic [1:0]  outChannel;
  logic [1:0]  outError;
  logic        wiggle = 1'b0;
  int          errors = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [35:0] userQ[$];
  logic [35:0] linkQ[$];

  always #10 clk_sys = ~clk_sys;

  sstrm_if #(.DATA_W(DATA_W), .CH_W(CH_W), .ERR_W(ERR_W)) lnk (.clk_sys(clk_sys), .rst_n(rst_n));
  sstrm_source #(.ERR_W(ERR_W), .MAX_CH(MAX_CH), .FIRST_MSB(FIRST_MSB)) u_sstrm_source (.link(lnk),
    .inValid(inValid), .inReady(inReady), .inData(inData), .inChannel(inChannel), .inError(inError));
  sstrm_sink #(.ERR_W(ERR_W), .MAX_CH(MAX_CH), .FIRST_MSB(FIRST_MSB)) u_sstrm_sink (.link(lnk),
    .outValid(outValid), .outReady(outReady), .outData(outData), .outChannel(outChannel),
    .outError(outError));
  sstrm_chk #(.DATA_W(DATA_W), .CH_W(CH_W), .ERR_W(ERR_W), .MAX_CH(MAX_CH)) u_sstrm_chk (.clk_sys(clk_sys),
    .rst_n(rst_n), .data(lnk.data), .channel(lnk.channel), .error(lnk.error), .valid(lnk.valid),
    .ready(lnk.ready));

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // First symbol sits in the low bits on the link
  function automatic logic [31:0] swapSym(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction

  always @(posedge clk_sys) begin
    cycles++;
    if (rst_n && lnk.valid && lnk.ready) begin
      chk({lnk.data, lnk.channel, lnk.error}, linkQ.pop_front());
    end
    if (rst_n && outValid && outReady) begin
      chk({outData, outChannel, outError}, userQ.pop_front());
    end
    // Timeout stays last so nothing runs after the closing report
    if (cycles == 4000) begin
      errors++;
      wrap_up();
    end
  end

  always @(negedge clk_sys) begin
    if (wiggle) begin
      outReady <= cycles[1];
    end
  end

  task automatic offer(input logic [35:0] w, output logic took);
    @(negedge clk_sys);
    {inData, inChannel, inError} = w;
    inValid = 1'b1;
    @(posedge clk_sys);
    took = inReady;
    if (took) begin
      userQ.push_back(w);
      linkQ.push_back({swapSym(w[35:4]), w[3:0]});
    end
  endtask

  task automatic send(input logic [35:0] w);
    logic took;
    took = 1'b0;
    for (int i = 0; i < 50 && !took; i++) begin
      offer(w, took);
    end
    chk({35'h0, took}, 36'h1);
  endtask

  task automatic idle(input int n);
    @(negedge clk_sys);
    inValid = 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic drain();
    @(negedge clk_sys);
    inValid = 1'b0;
    outReady = 1'b1;
    for (int i = 0; i < 40 && userQ.size() > 0; i++) begin
      @(posedge clk_sys);
    end
    chk(36'(userQ.size()), 36'h0);
  endtask

  task automatic t_single();
    send({32'h11223344, 2'h2, 2'h0});
    drain();
  endtask

  task automatic t_fill();
    logic took;
    int   n;
    n = 0;
    @(negedge clk_sys);
    outReady = 1'b0;
    for (int i = 0; i < 8; i++) begin
      offer({32'hA0B0C000 + 32'(n), 2'(n % 3), 2'(n)}, took);
      n += int'(took);
    end
    chk({35'h0, took}, 36'h0);
    chk(36'(n), 36'h6);
    idle(3);
    drain();
  endtask

  task automatic t_pulse();
    wiggle = 1'b1;
    for (int i = 0; i < 6; i++) begin
      send({32'h55667788 + 32'(i), 2'(i % 3), 2'(3 - i % 4)});
    end
    wiggle = 1'b0;
    drain();
  endtask

  task automatic t_midreset();
    @(negedge clk_sys);
    outReady = 1'b0;
    send({32'hCAFE0001, 2'h1, 2'h3});
    send({32'hCAFE0002, 2'h0, 2'h1});
    idle(2);
    @(negedge clk_sys);
    rst_n = 1'b0;
    userQ.delete();
    linkQ.delete();
    #1;
    chk({33'h0, lnk.valid, lnk.ready, outValid}, 36'h0);
    idle(2);
    @(negedge clk_sys);
    rst_n = 1'b1;
    outReady = 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({35'h0, outValid}, 36'h0);
    // Link must carry words again after a mid-run reset
    send({32'hCAFE0003, 2'h2, 2'h2});
    drain();
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    chk({33'h0, lnk.valid, lnk.ready, outValid}, 36'h0);
    @(negedge clk_sys);
    rst_n = 1'b1;
    outReady = 1'b1;
    @(posedge clk_sys);
    #1;
    chk({35'h0, lnk.ready}, 36'h1);
    t_single();
    t_fill();
    t_pulse();
    t_midreset();
    wrap_up();
  end
endmodule
`default_nettype wire
